/* logic/brg_pkg.sv */
// package for the multi-master i2c collision and baud generator block
// assumes a single 40 MHz clock domain and an axi4-lite register bus
package brg_pkg;
  // register byte offsets
  localparam logic [7:0] ofs_baud_reload = 8'h00;
  localparam logic [7:0] ofs_serial_buffer = 8'h04;
  localparam logic [7:0] ofs_control_two = 8'h08;
  localparam logic [7:0] ofs_status = 8'h0c;
  localparam logic [7:0] ofs_irq_status = 8'h10;
  localparam logic [7:0] ofs_irq_mask = 8'h14;
  // control_two_reg field positions
  localparam int bit_sen = 0;
  localparam int bit_rsen = 1;
  localparam int bit_pen = 2;
  localparam int bit_ack = 4;
  // irq status bits
  localparam int irq_bcl = 0;
  localparam int irq_done = 1;
  // reset values
  localparam logic [7:0] rst_reload = 8'h09;
  localparam logic [7:0] rst_zero8 = 8'h00;
  // last prescaler count; four oscillator cycles per instruction cycle
  localparam logic [1:0] presc_last = 2'h3;
  // axi response codes
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  // sequencer states, one-hot
  typedef enum logic [7:0] {
    st_idle = 8'h01,
    st_rs_sda_rel = 8'h02,
    st_rs_scl_rel = 8'h04,
    st_rs_hold = 8'h08,
    st_rs_low = 8'h10,
    st_p_sda_low = 8'h20,
    st_p_scl_rel = 8'h40,
    st_p_sda_rel = 8'h80
  } seq_state_t;
  // bus line pair
  typedef struct packed {
    logic scl;
    logic sda;
  } i2c_lines_t;
endpackage : brg_pkg

/* logic/i2c_master_collision_brg.sv */
// multi-master i2c repeated start and stop sequencer with reload baud counter
// assumes open-drain pins resolved outside; inputs synchronous to mclk
`timescale 1ns/10ps
module i2c_master_collision_brg
  import brg_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq
);

  // register state
  logic [7:0] reload_ff;         // baud_reload_reg
  logic [7:0] buffer_ff;         // serial_buffer_reg
  logic [7:0] ctrl2_ff;          // control_two_reg
  logic [1:0] irq_stat_ff;       // sticky events
  logic [1:0] irq_mask_ff;       // interrupt enables
  // baud counter state
  logic [7:0] baud_counter_ff;
  logic [1:0] presc_ff;
  logic run_ff;                  // counter running
  // line drive state, high means pulling low
  i2c_lines_t pull_ff;
  seq_state_t state_ff;
  seq_state_t nxt_state;
  // axi holding state
  logic aw_ff;
  logic w_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // bus line view
  i2c_lines_t line;
  assign line.scl = scl_i;
  assign line.sda = sda_i;

  // open-drain outputs: drive zero only when pulling
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = pull_ff.scl;
  assign sda_oe = pull_ff.sda;

  // instruction-cycle tick, one per four mclk cycles
  wire tick = run_ff && (presc_ff == presc_last);
  // expiry when the counter sits at zero on a tick
  wire expire = tick && (baud_counter_ff == rst_zero8);

  // write channel decode
  wire wr_go = aw_ff && w_ff && !bvalid_ff;
  wire wr_reload = wr_go && (awaddr_ff == ofs_baud_reload);
  wire wr_buffer = wr_go && (awaddr_ff == ofs_serial_buffer);
  wire wr_ctrl2 = wr_go && (awaddr_ff == ofs_control_two);
  wire wr_istat = wr_go && (awaddr_ff == ofs_irq_status);
  wire wr_imask = wr_go && (awaddr_ff == ofs_irq_mask);
  wire wr_hit = wr_reload | wr_buffer | wr_ctrl2 | wr_istat | wr_imask;
  wire wr_lane0 = wstrb_ff[0];
  wire idle_now = (state_ff == st_idle);

  // sequence requests from software, only taken while idle
  wire req_rsen = wr_ctrl2 && wr_lane0 && wdata_ff[bit_rsen] && idle_now;
  wire req_pen = wr_ctrl2 && wr_lane0 && wdata_ff[bit_pen] && idle_now;

  // collision detection per state
  logic bcl_event;
  logic seq_done;
  logic load_cnt;                // reload strobe into the counter
  logic start_cnt;
  always_comb begin
    nxt_state = state_ff;
    bcl_event = 1'b0;
    seq_done = 1'b0;
    load_cnt = 1'b0;
    start_cnt = 1'b0;
    case (state_ff)
      st_idle: begin
        if (req_rsen) begin
          nxt_state = st_rs_sda_rel;
        end else if (req_pen) begin
          nxt_state = st_p_sda_low;
        end
      end
      // sda released, wait for it high then count
      st_rs_sda_rel: begin
        if (!line.scl && !pull_ff.scl) begin
          bcl_event = 1'b1;
        end else if (!run_ff && line.sda) begin
          load_cnt = 1'b1;
          start_cnt = 1'b1;
        end else if (expire) begin
          nxt_state = st_rs_scl_rel;
        end
      end
      // scl released, sample sda once scl reads high
      st_rs_scl_rel: begin
        if (line.scl) begin
          if (!line.sda) begin
            bcl_event = 1'b1;
          end else begin
            load_cnt = 1'b1;
            start_cnt = 1'b1;
            nxt_state = st_rs_hold;
          end
        end
      end
      // second count: sda fall is harmless, scl fall collides
      st_rs_hold: begin
        if (!line.scl) begin
          bcl_event = 1'b1;
        end else if (expire) begin
          if (line.sda) begin
            load_cnt = 1'b1;
            nxt_state = st_rs_low;
          end
        end
      end
      // sda driven low, at expiry pull scl whatever it is
      st_rs_low: begin
        if (expire) begin
          seq_done = 1'b1;
          nxt_state = st_idle;
        end
      end
      // stop: sda pulled, wait for it low, then release scl
      st_p_sda_low: begin
        if (!line.sda) begin
          nxt_state = st_p_scl_rel;
        end
      end
      // scl released, on high count down
      st_p_scl_rel: begin
        if (!pull_ff.scl && line.scl && !run_ff) begin
          load_cnt = 1'b1;
          start_cnt = 1'b1;
        end else if (run_ff && !line.scl) begin
          bcl_event = 1'b1;
        end else if (expire) begin
          load_cnt = 1'b1;
          nxt_state = st_p_sda_rel;
        end
      end
      // sda released: sample after expiry
      st_p_sda_rel: begin
        if (!line.scl && !line.sda) begin
          bcl_event = 1'b1;
        end else if (expire) begin
          if (!line.sda) begin
            bcl_event = 1'b1;
          end else begin
            seq_done = 1'b1;
            nxt_state = st_idle;
          end
        end
      end
      default: begin
        nxt_state = st_idle;
      end
    endcase
    if (bcl_event) begin
      nxt_state = st_idle;
    end
  end

  // sequencer state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= st_idle;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // line drive: collision releases both lines
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pull_ff <= '0;
    end else if (bcl_event) begin
      pull_ff <= '0;
    end else if (req_rsen) begin
      pull_ff.sda <= 1'b0;                                         // scl is pulled low here
      pull_ff.scl <= 1'b1;
    end else if (req_pen) begin
      pull_ff.sda <= 1'b1;
      pull_ff.scl <= 1'b1;
    end else if (state_ff == st_rs_sda_rel && expire) begin
      pull_ff.scl <= 1'b0;
    end else if (state_ff == st_rs_hold && expire && line.sda) begin
      pull_ff.sda <= 1'b1;
    end else if (state_ff == st_rs_low && expire) begin
      pull_ff.scl <= 1'b1;
    end else if (state_ff == st_p_sda_low && !line.sda) begin
      pull_ff.scl <= 1'b0;
    end else if (state_ff == st_p_scl_rel && expire) begin
      pull_ff.sda <= 1'b0;
    end
  end

  // baud counter with reload, prescale by four
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      baud_counter_ff <= rst_zero8;
      presc_ff <= '0;
      run_ff <= 1'b0;
    end else begin
      presc_ff <= run_ff ? presc_ff + 2'h1 : 2'h0;
      // a new request also halts a free-running count so the sequence reloads it
      if (bcl_event || seq_done || req_rsen || req_pen) begin
        run_ff <= 1'b0;
      end else if (wr_buffer && idle_now) begin
        run_ff <= 1'b1;
        baud_counter_ff <= reload_ff;
        presc_ff <= 2'h0;
      end else if (start_cnt) begin
        run_ff <= 1'b1;
        presc_ff <= 2'h0;
      end
      if (load_cnt) begin
        baud_counter_ff <= reload_ff;
      end else if (tick && baud_counter_ff != rst_zero8) begin
        baud_counter_ff <= baud_counter_ff - 8'h01;
      end else if (expire && idle_now) begin
        baud_counter_ff <= reload_ff;                              // free reload
      end
    end
  end

  // software registers; enables clear on completion or collision
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reload_ff <= rst_reload;
      buffer_ff <= rst_zero8;
      ctrl2_ff <= rst_zero8;
      irq_mask_ff <= '0;
    end else begin
      if (wr_reload && wr_lane0) begin
        reload_ff <= wdata_ff[7:0];                                // not checked
      end
      if (wr_buffer && wr_lane0 && idle_now) begin
        buffer_ff <= wdata_ff[7:0];
      end
      if (wr_imask && wr_lane0) begin
        irq_mask_ff <= wdata_ff[1:0];
      end
      if (bcl_event || seq_done) begin
        ctrl2_ff[bit_sen] <= 1'b0;
        ctrl2_ff[bit_rsen] <= 1'b0;
        ctrl2_ff[bit_pen] <= 1'b0;
        ctrl2_ff[bit_ack] <= 1'b0;
      end else if (wr_ctrl2 && wr_lane0 && idle_now) begin
        ctrl2_ff <= wdata_ff[7:0];
      end
    end
  end

  // sticky interrupt status, set wins over write-one-to-clear
  wire [1:0] irq_set = {seq_done, bcl_event};
  wire [1:0] irq_clr = (wr_istat && wr_lane0) ? wdata_ff[1:0] : 2'h0;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // axi write: address and data latched in either order
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= resp_okay;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? resp_okay : resp_slverr;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_ff && !bvalid_ff;
  assign s_axi_wready = !w_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // axi read decode
  wire [7:0] status_byte = {2'h0, run_ff, pull_ff.scl, pull_ff.sda, line.scl, line.sda,
                            !idle_now};
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      ofs_baud_reload: rd_mux = {24'h0, reload_ff};
      ofs_serial_buffer: rd_mux = {24'h0, buffer_ff};
      ofs_control_two: rd_mux = {24'h0, ctrl2_ff};
      ofs_status: rd_mux = {16'h0, baud_counter_ff, status_byte};
      ofs_irq_status: rd_mux = {30'h0, irq_stat_ff};
      ofs_irq_mask: rd_mux = {30'h0, irq_mask_ff};
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_hit ? resp_okay : resp_slverr;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule : i2c_master_collision_brg

/* testbench/brg_asserts.sv */
// pin and register-bus assertions for the collision sequencer
// assumes one mclk domain; oe high means we pull that line low
`timescale 1ns/10ps
module brg_asserts
  import brg_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic irq
);
  // single domain, so one clocking and one disable for all
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // low data at our clock rise: another master sends a zero
  a_rs_sda_low: assert property (
    !scl_oe && !sda_oe && $rose(scl_i) && !sda_i |=> !sda_oe [*8])
    else $error("data driven after low sample at clock rise");
  // a foreign clock fall while our clock is free must end our sequence
  a_scl_fall_abort: assert property (
    !scl_oe && $fell(scl_i) |=> !sda_oe [*4])
    else $error("data still driven after foreign clock fall");
  // clock released only with data free eight cycles before and reading high the cycle before
  a_rs_count_first: assert property (
    $fell(scl_oe) && !sda_oe |-> !$past(sda_oe, 8) && $past(sda_i))
    else $error("clock released before the data count");
  // data is driven with the clock free only when both lines read high
  a_rs_both_high: assert property (
    $rose(sda_oe) && !scl_oe |-> $past(scl_i) && $past(sda_i))
    else $error("data driven while a line was low");
  // after data goes low at least eight cycles pass, then the clock is pulled
  a_rs_clock_low: assert property (
    $rose(sda_oe) && !scl_oe |-> !scl_oe [*8] ##[1:1000] scl_oe)
    else $error("clock not pulled one count after data");
  // stop frees the clock only once data has read low
  a_stop_scl_free: assert property (
    $fell(scl_oe) && sda_oe |-> !$past(sda_i))
    else $error("clock freed before data read low");
  // stop keeps data low while the counter runs after clock high
  a_stop_count: assert property (
    sda_oe && !scl_oe && $rose(scl_i) ##1 scl_i [*6] |-> sda_oe)
    else $error("data freed before the stop count ended");
  // no new write address while a response is pending
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address accepted during response");
  // refused reads carry zero data
  a_slverr_zero: assert property (
    s_axi_rvalid && s_axi_rresp == resp_slverr |-> s_axi_rdata == 32'h0)
    else $error("error read with nonzero data");
  c_rs_done: cover property ($rose(scl_oe) && sda_oe);
  c_irq_rise: cover property ($rose(irq));
  c_scl_fall: cover property (!scl_oe && $fell(scl_i));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == resp_slverr);
endmodule : brg_asserts

bind i2c_master_collision_brg brg_asserts brg_asserts_inst (.mclk(mclk), .reset_n(reset_n),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .scl_i(scl_i), .sda_i(sda_i),
  .scl_oe(scl_oe), .sda_oe(sda_oe), .irq(irq));

/* testbench/bus_partner.sv */
// other masters on the shared open-drain bus, with pull-ups
// assumes oe high means the block pulls that line low
`timescale 1ns/10ps
module bus_partner
  import brg_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [1:0] mode,
  input wire logic scl_oe,
  input wire logic sda_oe,
  output i2c_lines_t lines
);
  logic [2:0] high_cnt_ff; // cycles clock seen high
  logic pull_scl_ff; // other master holding clock low
  logic pull_sda; // other master sending a zero
  // mode 1 sends a zero as soon as our clock is freed
  assign pull_sda = (mode == 2'h1) && !scl_oe;
  // wired-and: a freed line rises through its pull-up
  assign lines.scl = !(scl_oe || pull_scl_ff);
  assign lines.sda = !(sda_oe || pull_sda);
  // mode 2 pulls the clock early in a high phase and keeps it down
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      high_cnt_ff <= 3'h0;
      pull_scl_ff <= 1'b0;
    end else begin
      high_cnt_ff <= (lines.scl && mode == 2'h2) ? high_cnt_ff + 3'h1 : 3'h0;
      pull_scl_ff <= (mode == 2'h2) && (pull_scl_ff || high_cnt_ff == 3'h3);
    end
  end
endmodule : bus_partner

/* testbench/testbench.sv */
// register-level bench for the collision sequencer and baud counter
// assumes bus_partner on the lines; checker bound to the design
`timescale 1ns/10ps
module testbench
  import brg_pkg::*;
;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf; // whole word every write
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, wresp;
  logic [1:0] pmode = 2'h0; // partner behaviour
  logic scl_o, scl_oe, sda_o, sda_oe, irq, sda_prev = 1'b0, scl_prev = 1'b0;
  i2c_lines_t lines;
  int num_errors = 0, n_compared = 0, cyc = 0, t_sda = 0, t_scl = 0, rl, i, j;
  // sequence table: enable bit, partner mode, collision expected
  int sb[10] = '{bit_rsen, bit_pen, bit_rsen, bit_pen, bit_rsen, bit_rsen, bit_rsen,
    bit_rsen, bit_rsen, bit_pen};
  logic [1:0] sm[10] = '{0, 0, 0, 1, 0, 2, 0, 1, 0, 2};
  logic sc[10] = '{0, 0, 0, 1, 0, 1, 0, 1, 0, 1};
  always #12.5 mclk = ~mclk;
  i2c_master_collision_brg i2c_master_collision_brg_inst (.mclk, .reset_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_i(lines.scl), .scl_o,
    .scl_oe, .sda_i(lines.sda), .sda_o, .sda_oe, .irq);
  bus_partner bus_partner_inst (.mclk, .reset_n, .mode(pmode), .scl_oe, .sda_oe, .lines);
  // cycle stamps of our pulls, sampled away from the edge
  always @(negedge mclk) begin
    cyc <= cyc + 1;
    if (sda_oe && !sda_prev) t_sda <= cyc;
    if (scl_oe && !scl_prev) t_scl <= cyc;
    sda_prev <= sda_oe;
    scl_prev <= scl_oe;
  end
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask : chk
  // one write; each channel held until its ready is sampled
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    int n;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    for (n = 0; n < 99 && b; n++) begin
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
      s_axi_bready <= 1'b1;
      @(negedge mclk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      if (s_axi_bvalid) wresp = s_axi_bresp;
      b = b && !s_axi_bvalid;
      @(posedge mclk);
    end
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    // let an edge pass so a following call never re-drives in this step
    @(posedge mclk);
    if (b) begin
      chk("write answer", 32'h0, 32'h1);
      end_sim();
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rd;
    int n;
    ar = 1'b1;
    rd = 1'b1;
    s_axi_araddr <= a;
    for (n = 0; n < 99 && rd; n++) begin
      s_axi_arvalid <= ar;
      s_axi_rready <= 1'b1;
      @(negedge mclk);
      ar = ar && !s_axi_arready;
      if (s_axi_rvalid) begin
        rd = 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
      @(posedge mclk);
    end
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    // same spacing rule as the write task
    @(posedge mclk);
    if (rd) begin
      chk("read answer", 32'h0, 32'h1);
      end_sim();
    end
  endtask : axi_rd
  task automatic chk_irq(input logic exp);
    @(negedge mclk);
    chk("irq", {31'h0, irq}, {31'h0, exp});
    @(posedge mclk);
  endtask : chk_irq
  // start one sequence, wait for its interrupt, then check the outcome
  task automatic run_seq(input int b, input logic [1:0] m, input logic coll);
    int n;
    axi_wr(ofs_irq_status, 32'h3);
    pmode <= m;
    axi_wr(ofs_control_two, 32'h1 << b);
    for (n = 0; n < 3000 && irq !== 1'b1; n++) @(negedge mclk);
    @(posedge mclk);
    if (irq !== 1'b1) begin
      chk("sequence end", 32'h0, 32'h1);
      end_sim();
    end
    axi_rd(ofs_irq_status, rv, rr);
    chk("collision flag", {31'h0, rv[irq_bcl]}, {31'h0, coll});
    chk("done flag", {31'h0, rv[irq_done]}, {31'h0, !coll});
    axi_rd(ofs_status, rv, rr);
    chk("counter stopped", {31'h0, rv[5]}, 32'h0);
    if (coll) begin
      chk("lines freed", {30'h0, rv[4:3]}, 32'h0);
      axi_rd(ofs_control_two, rv, rr);
      chk("enables cleared", {29'h0, rv[2:0]}, 32'h0);
    end else if (b == bit_rsen) begin
      chk("both pulled", {30'h0, rv[4:3]}, 32'h3);
      chk("clock half period", 32'(t_scl - t_sda), 32'(4 * (rl + 1)));
    end else begin
      chk("stop freed", {30'h0, rv[4:3]}, 32'h0);
    end
    pmode <= 2'h0;
  endtask : run_seq
  // main sequence
  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    axi_rd(ofs_baud_reload, rv, rr);
    chk("reload reset", rv, {24'h0, rst_reload});
    axi_rd(8'h20, rv, rr);
    chk("unmapped resp", {30'h0, rr}, {30'h0, resp_slverr});
    chk("unmapped data", rv, 32'h0);
    axi_wr(8'h20, 32'h0);
    chk("unmapped write", {30'h0, wresp}, {30'h0, resp_slverr});
    chk("open drain levels", {30'h0, scl_o, sda_o}, 32'h0);
    axi_wr(ofs_irq_mask, 32'h3);
    for (i = 0; i < 2; i++) begin
      rl = 3 + 2 * i;
      axi_wr(ofs_baud_reload, 32'(rl));
      axi_rd(ofs_baud_reload, rv, rr);
      chk("reload", rv, 32'(rl));
      for (j = 0; j < 10; j++) run_seq(sb[j], sm[j], sc[j]);
    end
    axi_wr(ofs_serial_buffer, 32'h5a);
    axi_rd(ofs_status, rv, rr);
    chk("counter running", {31'h0, rv[5]}, 32'h1);
    axi_wr(ofs_irq_mask, 32'h0);
    chk_irq(1'b0);
    axi_wr(ofs_irq_mask, 32'h1);
    chk_irq(1'b1);
    axi_wr(ofs_irq_status, 32'h1);
    chk_irq(1'b0);
    end_sim();
  end
endmodule : testbench
